// ===== design/align_pkg.sv
package align_pkg;

    // clock rates and derived cycle counts
    localparam int unsigned ACLK_HZ        = 20_000_000;
    localparam int unsigned SYS_CLK_HZ     = 10_000_000;
    localparam int unsigned SYS_DIV        = ACLK_HZ / SYS_CLK_HZ;
    localparam int unsigned PIN_PULSE_NS   = 200;
    localparam int unsigned PIN_PULSE_CYC  =
        (PIN_PULSE_NS * (ACLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned RELEASE_SYS    = 2;
    localparam int unsigned RELEASE_CYC    = RELEASE_SYS * SYS_DIV;

    // channel and source layout
    localparam int unsigned NUM_CH         = 8;
    localparam int unsigned NUM_POSTDIV    = 4;
    localparam int unsigned DIV_W          = 20;
    localparam int unsigned SRC_W          = 3;

    // register byte offsets
    localparam logic [7:0] CH_CFG_BASE     = 8'h00;
    localparam logic [7:0] CTRL_OFS        = 8'h20;
    localparam logic [7:0] STATUS_OFS      = 8'h24;

    // channel config fields
    localparam int unsigned CFG_SRC_LSB    = 0;
    localparam int unsigned CFG_ALIGN_BIT  = 3;
    localparam int unsigned CFG_DIV_LSB    = 8;
    localparam logic [31:0] CH_CFG_RESET   = 32'h0000_0200;

    // control fields
    localparam int unsigned CTRL_SOFT_BIT  = 0;
    localparam int unsigned CTRL_MUTE_BIT  = 1;
    localparam int unsigned CTRL_BANK_LSB  = 8;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

    // status fields
    localparam int unsigned STAT_REQ_BIT   = 0;
    localparam int unsigned STAT_HOLD_LSB  = 8;
    localparam int unsigned STAT_OUT_LSB   = 16;

    // output mux sources
    typedef enum logic [SRC_W-1:0] {
        SRC_PLL1_PRIMARY   = 3'h0,
        SRC_PLL1_SECONDARY = 3'h1,
        SRC_PLL2_PRIMARY   = 3'h2,
        SRC_PLL2_SECONDARY = 3'h3,
        SRC_XO             = 3'h4,
        SRC_TCXO           = 3'h5,
        SRC_DPLL_REF       = 3'h6
    } src_sel_e;

    localparam logic [1:0] AXI_OKAY        = 2'h0;
    localparam logic [1:0] AXI_SLVERR      = 2'h2;

endpackage : align_pkg

// ===== design/sys_tick_gen.sv
`timescale 1ns/1ps
// divides aclk down to the internal system clock rate as an enable pulse
module sys_tick_gen #(
    parameter int unsigned DIV = align_pkg::SYS_DIV
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    output logic      tick
);

    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

    initial begin
        if (DIV < 1) begin
            $error("sys_tick_gen: DIV must be at least one");
        end
    end

    logic [CW-1:0] cnt_q;

    // free-running count, pulse on the last count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q == CW'(DIV - 1)) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick  <= 1'b0;
        end
    end

endmodule : sys_tick_gen

// ===== design/chan_divider.sv
`timescale 1ns/1ps
// one output divider stepped by its selected source tick
module chan_divider #(
    parameter int unsigned W = align_pkg::DIV_W
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         src_tick,
    input  wire logic         hold,
    input  wire logic [W-1:0] div,
    output logic              out
);

    initial begin
        if (W < 2) begin
            $error("chan_divider: W must be at least two");
        end
    end

    logic [W-1:0] cnt_q;
    logic         bypass;

    assign bypass = (div <= W'(1));

    // hold parks a non-bypass divider at count zero with a low output, so every
    // member of a group rises on the same first tick after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            out   <= 1'b0;
        end else if (bypass) begin
            cnt_q <= '0;
            out   <= src_tick;
        end else if (hold) begin
            cnt_q <= '0;
            out   <= 1'b0;
        end else if (src_tick) begin
            cnt_q <= (cnt_q == div - 1'b1) ? '0 : cnt_q + 1'b1;
            out   <= (cnt_q < (div >> 1));
        end
    end

    held_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (hold && !bypass) |=> !out)
        else $error("held divider output not low");

endmodule : chan_divider

// ===== design/output_divider_sync_group.sv
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Operation
// - grouped dividers leave reset on the same post-divider tick, rising together.
// - a divider joins a group only with its align enable bit set to one.
// - only dividers selecting the same post-divider of the same PLL group together.
// - each post-divider needs its bank enable for outputs 0-3 or 4-7.
// - alignment is requested by the pin low or the soft request bit high.
// - while requested, enabled dividers are held in reset and their drivers muted.
// - hold and mute start only after the last group output has gone low; here each member parks once its own output is low.
// - on request removal grouped outputs restart together with aligned phases.
// - the request is sampled and qualified on the 10 MHz system tick.
// - release follows request removal within two system clock cycles; here hold clears on the next group tick after req_q drops.
// - channels with align enable zero ignore alignment and run normally.
// - post-divider clocks keep running during alignment for ungrouped channels.
// - a divide-by-one bypass divider is never gated by alignment.
// - with the mute option set, outputs restart glitch-free after release.
module output_divider_sync_group #(
    parameter int unsigned NUM_CH = align_pkg::NUM_CH,
    parameter int unsigned DIV_W  = align_pkg::DIV_W
) (
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    // alignment pin, low requests alignment
    input  wire logic                            align_request_pin_n,
    // post-divider ticks: pll1 primary, pll1 secondary, pll2 primary, pll2 secondary
    input  wire logic [align_pkg::NUM_POSTDIV-1:0] postdiv_tick,
    // bypass source ticks: xo, tcxo, dpll reference
    input  wire logic [2:0]                      bypass_tick,
    output logic      [NUM_CH-1:0]               clk_out,
    // AXI4-Lite slave
    input  wire logic [7:0]                      s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [31:0]                     s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    input  wire logic [7:0]                      s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [31:0]                          s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready
);

    initial begin
        if (NUM_CH != align_pkg::NUM_CH || DIV_W != align_pkg::DIV_W) begin
            $error("output_divider_sync_group: channel count and width are fixed");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file

    logic [31:0]       ch_cfg_q [NUM_CH];
    logic [31:0]       ctrl_q;
    logic              wr_fire;
    logic              wr_hit;
    logic [31:0]       rd_word;
    logic              rd_hit;

    // decode a byte address to a channel slot, index NUM_CH means none
    function automatic int unsigned ch_slot(input logic [7:0] addr);
        int unsigned idx;
        idx = NUM_CH;
        if (addr[1:0] == 2'h0 && addr < align_pkg::CH_CFG_BASE + 8'(4 * NUM_CH)) begin
            idx = int'(addr[7:2] - align_pkg::CH_CFG_BASE[7:2]);
        end
        return idx;
    endfunction : ch_slot

    // merge written byte lanes into a register word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  st);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // address and data are taken together; no new write until the response goes
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign wr_fire       = s_axi_awready;
    assign wr_hit        = (ch_slot(s_axi_awaddr) < NUM_CH)
                        || (s_axi_awaddr == align_pkg::CTRL_OFS)
                        || (s_axi_awaddr == align_pkg::STATUS_OFS);

    // channel configuration words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ch_cfg_q[i] <= align_pkg::CH_CFG_RESET;
            end
        end else if (wr_fire && ch_slot(s_axi_awaddr) < NUM_CH) begin
            ch_cfg_q[ch_slot(s_axi_awaddr)] <=
                lane_merge(ch_cfg_q[ch_slot(s_axi_awaddr)], s_axi_wdata, s_axi_wstrb);
        end
    end

    // global control: soft request, mute option and bank enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= align_pkg::CTRL_RESET;
        end else if (wr_fire && s_axi_awaddr == align_pkg::CTRL_OFS) begin
            ctrl_q <= lane_merge(ctrl_q, s_axi_wdata, s_axi_wstrb);
        end
    end

    // write response, unmapped addresses answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= align_pkg::AXI_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? align_pkg::AXI_OKAY : align_pkg::AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request qualification

    logic sys_tick;
    logic req_raw;
    logic req_q;

    sys_tick_gen #(
        .DIV (align_pkg::SYS_DIV)
    ) u_sys_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (sys_tick)
    );

    // either source asserts the request
    assign req_raw = !align_request_pin_n || ctrl_q[align_pkg::CTRL_SOFT_BIT];

    // sampling only on the system tick is why the pin pulse must span a tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q <= 1'b0;
        end else if (sys_tick) begin
            req_q <= req_raw;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // group membership and hold

    logic [NUM_CH-1:0]                   member;
    logic [NUM_CH-1:0]                   ch_tick;
    logic [NUM_CH-1:0]                   grp_tick;
    logic [NUM_CH-1:0]                   div_out;
    logic [NUM_CH-1:0]                   hold_q;
    logic [NUM_CH-1:0]                   mute_q;
    logic [NUM_CH-1:0]                   div_prev_q;
    logic [NUM_CH-1:0]                   ch_low;

    // post-divider index of a channel's source
    function automatic logic [1:0] grp_of(input logic [31:0] cfg);
        return cfg[align_pkg::CFG_SRC_LSB +: 2];
    endfunction : grp_of

    // true when a channel's source is a pll post-divider
    function automatic logic from_postdiv(input logic [31:0] cfg);
        return !cfg[align_pkg::CFG_SRC_LSB + 2];
    endfunction : from_postdiv

    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
            logic [2:0]       src;
            logic [DIV_W-1:0] dval;
            logic             bank;

            assign src  = ch_cfg_q[i][align_pkg::CFG_SRC_LSB +: 3];
            assign dval = ch_cfg_q[i][align_pkg::CFG_DIV_LSB +: DIV_W];
            // bank bits: two per post-divider, lower then upper outputs
            assign bank = ctrl_q[align_pkg::CTRL_BANK_LSB
                                 + 2 * int'(grp_of(ch_cfg_q[i])) + (i / 4)];

            // post-divider ticks feed every channel selecting them, whatever the request state
            assign ch_tick[i]  = from_postdiv(ch_cfg_q[i])
                               ? postdiv_tick[grp_of(ch_cfg_q[i])]
                               : ((src == 3'h7) ? 1'b0 : bypass_tick[src[1:0]]);
            assign grp_tick[i] = postdiv_tick[grp_of(ch_cfg_q[i])];

            // bypass sources never join, as from_postdiv keeps them out in hardware
            assign member[i] = ch_cfg_q[i][align_pkg::CFG_ALIGN_BIT]
                            && from_postdiv(ch_cfg_q[i])
                            && bank
                            && (dval > DIV_W'(1));

            chan_divider #(
                .W (DIV_W)
            ) u_div (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .src_tick (ch_tick[i]),
                .hold     (hold_q[i]),
                .div      (dval),
                .out      (div_out[i])
            );
        end
    endgenerate

    // a member parks only once its own output has finished its high phase;
    // waiting for all members at once could stall forever on unaligned phases
    always_comb begin
        ch_low = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (member[i] && !div_out[i]) begin
                ch_low[i] = 1'b1;
            end
        end
    end

    // each member parks on a group tick once low; all leave on the same
    // group tick, so every member restarts phase aligned
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_q <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (!member[i]) begin
                    hold_q[i] <= 1'b0;
                end else if (grp_tick[i]) begin
                    if (!req_q) begin
                        hold_q[i] <= 1'b0;
                    end else if (ch_low[i]) begin
                        hold_q[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // remember the divider level to spot its first falling edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_prev_q <= '0;
        end else begin
            div_prev_q <= div_out;
        end
    end

    // mute follows hold; with the option set it lingers through the first high
    // phase, trading one output period of latency for only full pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mute_q <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (hold_q[i]) begin
                    mute_q[i] <= 1'b1;
                end else if (!member[i] || !ctrl_q[align_pkg::CTRL_MUTE_BIT]) begin
                    mute_q[i] <= 1'b0;
                end else if (div_prev_q[i] && !div_out[i]) begin
                    mute_q[i] <= 1'b0;
                end
            end
        end
    end

    // driver gating
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            clk_out[i] = div_out[i] && !hold_q[i] && !mute_q[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        if (ch_slot(s_axi_araddr) < NUM_CH) begin
            rd_word = ch_cfg_q[ch_slot(s_axi_araddr)];
        end else if (s_axi_araddr == align_pkg::CTRL_OFS) begin
            rd_word = ctrl_q;
        end else if (s_axi_araddr == align_pkg::STATUS_OFS) begin
            rd_word[align_pkg::STAT_REQ_BIT]                 = req_q;
            rd_word[align_pkg::STAT_HOLD_LSB +: NUM_CH]      = hold_q;
            rd_word[align_pkg::STAT_OUT_LSB +: NUM_CH]       = clk_out;
        end else begin
            rd_hit  = 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    // read data registered, one read outstanding at most
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= align_pkg::AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? align_pkg::AXI_OKAY : align_pkg::AXI_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    req_or_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (sys_tick && (!align_request_pin_n || ctrl_q[align_pkg::CTRL_SOFT_BIT]))
        |=> req_q)
        else $error("request not qualified");

    req_tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!$past(sys_tick) && $past(aresetn)) |-> $stable(req_q))
        else $error("request changed off the system tick");

    nonmember_free_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !member[0] |=> !hold_q[0])
        else $error("non-member channel held");

    group_same_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (member[0] && member[6] && grp_of(ch_cfg_q[0]) == grp_of(ch_cfg_q[6])
         && hold_q[0] && hold_q[6]
         && $stable(ch_cfg_q[0]) && $stable(ch_cfg_q[6]))
        |=> (hold_q[0] == hold_q[6]) || !member[0] || !member[6])
        else $error("group members left hold apart");

    enter_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(hold_q[0]) |-> !$past(div_out[0]))
        else $error("hold entered while output high");

    release_fast_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (hold_q[0] && !req_q && grp_tick[0]) |=> !hold_q[0])
        else $error("hold not released on tick");

    muted_a: assert property (@(posedge aclk) disable iff (!aresetn)
        hold_q[0] |-> !clk_out[0])
        else $error("held output not muted");

    bypass_free_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ch_cfg_q[0][align_pkg::CFG_DIV_LSB +: DIV_W] <= DIV_W'(1)) |-> !member[0])
        else $error("bypass divider grouped");

endmodule : output_divider_sync_group

// ===== verif/align_host_model.sv
`timescale 1ns/1ps
// far-side system logic: post-divider tick sources and the alignment pin driver
module align_host_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        pulse_go,
    input  wire logic [15:0] pulse_len,
    output logic             align_request_pin_n,
    output logic [3:0]       postdiv_tick
);
    localparam logic [15:0] MIN_LOW = 16'(align_pkg::PIN_PULSE_CYC + 1);
    logic [7:0]  cnt_q;
    logic [15:0] low_q;
    // free-running tick base, never paused by alignment
    always_ff @(posedge aclk) begin
        cnt_q <= aresetn ? cnt_q + 8'h01 : 8'h00;
    end
    // post-divider g pulses every g+2 cycles so groups see different rates
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            postdiv_tick[g] = (cnt_q % (g + 2)) == 0;
        end
    end
    // short requests are stretched past 200 ns, or the system tick could miss them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_q <= 16'h0000;
        end else if (pulse_go) begin
            low_q <= (pulse_len > MIN_LOW) ? pulse_len : MIN_LOW;
        end else if (low_q != 16'h0000) begin
            low_q <= low_q - 16'h0001;
        end
    end
    assign align_request_pin_n = (low_q == 16'h0000);
endmodule : align_host_model

// ===== verif/output_divider_sync_group_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end
module output_divider_sync_group_test;
    logic aclk, aresetn, pin_n, pulse_go, awvalid, awready, wvalid, wready;
    logic bvalid, bready, arvalid, arready, rvalid, rready;
    logic [3:0]  ptick, wstrb;
    logic [2:0]  bypass_tick;
    logic [7:0]  clk_out, awaddr, araddr;
    logic [15:0] pulse_len;
    logic [31:0] wdata, rdata, m_cfg[8], m_ctrl;
    logic [1:0]  bresp, rresp;
    int          num_errors = 0;
    int          cmp_count = 0;
    localparam logic [31:0] BANK = 32'h0000_2300;
    output_divider_sync_group dut_u (.aclk(aclk), .aresetn(aresetn),
        .align_request_pin_n(pin_n), .postdiv_tick(ptick), .bypass_tick(bypass_tick),
        .clk_out(clk_out), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    align_host_model host_u (.aclk(aclk), .aresetn(aresetn), .pulse_go(pulse_go),
        .pulse_len(pulse_len), .align_request_pin_n(pin_n), .postdiv_tick(ptick));
    ////////////////////////////////////////////////////////////////////////////////
    always #25 aclk = ~aclk;
    // bypass sources are random so ungated channels see irregular ticks
    always @(posedge aclk) bypass_tick <= 3'($urandom);
    // expected group members, worked out from the modelled registers
    function automatic logic [7:0] member_mask();
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m[i] = m_cfg[i][3] && m_cfg[i][2:0] < 3'h4 && m_cfg[i][27:8] > 20'h1
                   && m_ctrl[8 + 2 * m_cfg[i][2:0] + i / 4];
        end
        return m;
    endfunction : member_mask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        // address and data drop at the edge that takes them, bready at the answer
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) begin
                awvalid <= 1'b0;
                wvalid  <= 1'b0;
            end
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        if (bvalid !== 1'b1) num_errors++;
        `CHK(bresp, er)
        if (er == align_pkg::AXI_OKAY && a == align_pkg::CTRL_OFS) m_ctrl = d;
        else if (er == align_pkg::AXI_OKAY) m_cfg[a[4:2]] = d;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        if (rvalid !== 1'b1) num_errors++;
        d = rdata; r = rresp;
    endtask : axi_rd
    // all config words, control, and one unmapped place against the model
    task automatic check_regs();
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 10; i++) begin
            axi_rd((i == 9) ? 8'h28 : 8'(i * 4), d, r);
            `CHK(r, (i == 9) ? align_pkg::AXI_SLVERR : align_pkg::AXI_OKAY)
            `CHK(d, (i < 8) ? m_cfg[i] : (i == 8) ? m_ctrl : 32'h0)
        end
    endtask : check_regs
    task automatic check_held();
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  m;
        logic        p1, p4;
        int          t1, t4;
        m = member_mask(); t1 = 0; t4 = 0;
        axi_rd(align_pkg::STATUS_OFS, d, r);
        `CHK(d[0], 1'b1)
        `CHK(d[15:8], m)
        `CHK(d[23:16] & m, 8'h00)
        p1 = clk_out[1]; p4 = clk_out[4];
        repeat (16) begin
            @(posedge aclk); #1;
            `CHK(clk_out & m, 8'h00)
            t1 += int'(clk_out[1] != p1); t4 += int'(clk_out[4] != p4);
            p1 = clk_out[1]; p4 = clk_out[4];
        end
        `CHK(t1 > 0, 1'b1)
        `CHK(t4 > 0, 1'b1)
    endtask : check_held
    task automatic check_release();
        logic [31:0] d;
        logic [1:0]  r;
        int          rises;
        rises = 0;
        repeat (8) @(posedge aclk);
        axi_rd(align_pkg::STATUS_OFS, d, r);
        `CHK(d[15:0], 16'h0000)
        repeat (40) begin
            @(posedge aclk); #1;
            `CHK({clk_out[6], clk_out[7]}, {2{clk_out[0]}})
            rises += int'(clk_out[0]);
        end
        `CHK(rises > 0, 1'b1)
    endtask : check_release
    task automatic end_sim();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        end_sim();
    end
    initial begin
        logic [19:0] dv;
        logic [2:0]  src[8] = '{3'h0, 3'h0, 3'h1, 3'h4, 3'h0, 3'h2, 3'h0, 3'h0};
        aclk = 0; aresetn = 0; pulse_go = 0; pulse_len = 16'h0; bypass_tick = 3'h0;
        awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; wstrb = 4'hF;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
        void'($urandom(32'hABCB6520));
        foreach (m_cfg[i]) m_cfg[i] = align_pkg::CH_CFG_RESET;
        m_ctrl = align_pkg::CTRL_RESET;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        check_regs();
        axi_wr(8'h2C, 32'hFFFF_FFFF, align_pkg::AXI_SLVERR);
        // ch1 is unaligned, ch2 lacks its bank, ch3 is xo, ch4 bypasses
        dv = 20'(2 + $urandom % 4);
        for (int i = 0; i < 8; i++) begin
            axi_wr(8'(i * 4), {4'h0, (i == 4) ? 20'h1 : (i == 1) ? 20'(3 + $urandom % 5) :
                   (i == 2 || i == 3 || i == 5) ? 20'h2 : dv, 4'h0,
                   i != 1 && src[i] < 3'h4, src[i]}, align_pkg::AXI_OKAY);
        end
        axi_wr(align_pkg::CTRL_OFS, BANK, align_pkg::AXI_OKAY);
        check_regs();
        // pin request held well past the minimum width
        @(posedge aclk);
        pulse_go <= 1'b1; pulse_len <= 16'd60;
        @(posedge aclk);
        pulse_go <= 1'b0;
        repeat (30) @(posedge aclk);
        check_held();
        for (int n = 0; n < 100 && pin_n !== 1'b1; n++) @(posedge aclk);
        if (pin_n !== 1'b1) num_errors++;
        check_release();
        // soft request with the mute option on
        axi_wr(align_pkg::CTRL_OFS, BANK | 32'h3, align_pkg::AXI_OKAY);
        repeat (20) @(posedge aclk);
        check_held();
        axi_wr(align_pkg::CTRL_OFS, BANK | 32'h2, align_pkg::AXI_OKAY);
        check_release();
        end_sim();
    end
endmodule : output_divider_sync_group_test
